// ### design/otvo_limits.sv
// otvo_limits: warning limit, input overvoltage threshold and reaction byte,
// with comparators, status pulses and the overvoltage shutdown/restart sequencer.
// assumes a command front end delivering decoded reads/writes, same-clock
// telemetry, and a free running switching clock sampled as a pin.
// Behaviour
// - warning limit word, exponent resets zero
// - temperature at limit sets flags, notifies
// - out-of-range writes flag communication error
// - running limit kept at full resolution
// - restore rounds limit to whole degrees
// - limit of 255 disables the warning
// - limit is fault release, else 20 below
// - release fault when temperature under threshold
// - overvoltage threshold, declare at reaching it
// - threshold 4 to 20 V, quarter volts
// - overvoltage sets input status bits, notifies
// - reaction register is one byte
// - code 00 ignores, keeps switching
// - code 01 waits cycles then shuts down
// - code 10 shuts down at once
// - code 11 is rejected as invalid
// - retry field latches, counts, or retries forever
// - attempts under overvoltage still counted
// - delay codes 0-4: one or three cycles
// - delay codes 5-7: seven cycles
`timescale 1ns/1ps
module otvo_limits
    import otvo_pkg::*;
(
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire logic                         cmd_wr,
    input  wire logic                         cmd_rd,
    input  wire logic [7:0]                   cmd_code,
    input  wire logic [15:0]                  cmd_wdata,
    input  wire logic                         nvm_restore,
    input  wire logic [10:0]                  nvm_warn_mantissa,
    input  wire logic [10:0]                  nvm_ovp_mantissa,
    input  wire logic [7:0]                   nvm_reaction,
    input  wire logic signed [OTVO_TEL_W-1:0] temperature,
    input  wire logic signed [OTVO_TEL_W-1:0] power_input_voltage,
    input  wire logic [15:0]                  overtemp_fault_threshold,
    input  wire logic [19:0]                  soft_start_rise_time,
    input  wire logic                         converter_on,
    input  wire logic                         pwm_clk,
    output logic [15:0]                       cmd_rdata_q,
    output logic                              cmd_ack_q,
    output otvo_status_t                      status_q,
    output logic                              ot_release_q,
    output logic                              switching_q
);
    logic [15:0] overtemp_warning_threshold_q;
    logic [15:0] input_overvoltage_threshold_q;
    logic [7:0]  input_overvoltage_reaction_q;
    logic        nvm_load_q;
    otvo_fix_t   wfix;
    otvo_fix_t   warn_fix;
    otvo_fix_t   ovp_fix;
    otvo_fix_t   fault_fix;
    otvo_fix_t   rnd;
    logic        wr_valid;
    logic        ot_warn_q;
    logic        ov_now_q;
    logic        pwm_rise;
    otvo_state_t state_q;
    logic [2:0]  dly_cnt_q;
    logic [19:0] rise_cnt_q;
    logic [2:0]  mult_cnt_q;
    logic [2:0]  tries_q;
    logic [1:0]  ovp_reaction_code;
    logic [2:0]  ovp_restart_count;
    logic [2:0]  ovp_delay_code;
    logic        restart_wait_period_done;

    assign ovp_reaction_code = input_overvoltage_reaction_q[OTVO_CODE_LSB +: 2];
    assign ovp_restart_count = input_overvoltage_reaction_q[OTVO_COUNT_LSB +: 3];
    assign ovp_delay_code    = input_overvoltage_reaction_q[OTVO_DELAY_LSB +: 3];

    assign wfix      = otvo_lin_to_fix(cmd_wdata);
    assign warn_fix  = otvo_lin_to_fix(overtemp_warning_threshold_q);
    assign ovp_fix   = otvo_lin_to_fix(input_overvoltage_threshold_q);
    assign fault_fix = otvo_lin_to_fix(overtemp_fault_threshold);

    always_comb begin
        wr_valid = 1'b1;
        unique case (cmd_code)
            OTVO_CMD_WARN:
                wr_valid = (wfix == OTVO_WARN_OFF_FIX) ||
                    (wfix >= otvo_fix_t'(OTVO_WARN_MIN_C * (1 << OTVO_FRAC)) &&
                     wfix <= otvo_fix_t'(OTVO_WARN_MAX_C * (1 << OTVO_FRAC)));
            OTVO_CMD_OVP:
                wr_valid = wfix >= otvo_fix_t'(OTVO_OVP_MIN_V * (1 << OTVO_FRAC)) &&
                    wfix <= otvo_fix_t'(OTVO_OVP_MAX_V * (1 << OTVO_FRAC)) &&
                    wfix[OTVO_FRAC-OTVO_OVP_STEP_SH-1:0] == '0;
            OTVO_CMD_REACT:
                wr_valid = cmd_wdata[OTVO_CODE_LSB +: 2] != OTVO_REACT_BAD;
            default: wr_valid = 1'b1;
        endcase
    end

    // restore values are whole degrees and quarter volts
    always_comb begin
        rnd = (warn_fix + otvo_fix_t'(1 << (OTVO_FRAC - 1))) >>> OTVO_FRAC;
        if (rnd < otvo_fix_t'(OTVO_WARN_MIN_C)) begin
            rnd = otvo_fix_t'(OTVO_WARN_MIN_C);
        end else if (rnd > otvo_fix_t'(OTVO_WARN_MAX_C)) begin
            rnd = otvo_fix_t'(OTVO_WARN_MAX_C);
        end
    end

    otvo_fix_t rnd_v;
    always_comb begin
        rnd_v = (ovp_fix + otvo_fix_t'(1 << (OTVO_FRAC - OTVO_OVP_STEP_SH - 1)))
            >>> (OTVO_FRAC - OTVO_OVP_STEP_SH);
        if (rnd_v < otvo_fix_t'(OTVO_OVP_MIN_V << OTVO_OVP_STEP_SH)) begin
            rnd_v = otvo_fix_t'(OTVO_OVP_MIN_V << OTVO_OVP_STEP_SH);
        end else if (rnd_v > otvo_fix_t'(OTVO_OVP_MAX_V << OTVO_OVP_STEP_SH)) begin
            rnd_v = otvo_fix_t'(OTVO_OVP_MAX_V << OTVO_OVP_STEP_SH);
        end
    end

    // exponent reset, mantissa from storage at first edge after release
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            overtemp_warning_threshold_q  <= {OTVO_WARN_EXP_RST, 11'h000};
            input_overvoltage_threshold_q <= {OTVO_OVP_EXP_RST, 11'h000};
            input_overvoltage_reaction_q  <= 8'h00;
            nvm_load_q                    <= 1'b1;
        end else if (nvm_load_q) begin
            nvm_load_q                    <= 1'b0;
            overtemp_warning_threshold_q  <= {OTVO_WARN_EXP_RST, nvm_warn_mantissa};
            input_overvoltage_threshold_q <= {OTVO_OVP_EXP_RST, nvm_ovp_mantissa};
            input_overvoltage_reaction_q  <= nvm_reaction;
        end else if (nvm_restore) begin
            // round warning limit, disabled value kept
            if (warn_fix != OTVO_WARN_OFF_FIX) begin
                overtemp_warning_threshold_q <= {OTVO_WARN_EXP_RST, rnd[10:0]};
            end
            input_overvoltage_threshold_q <= {OTVO_OVP_EXP_RST, rnd_v[10:0]};
        end else if (cmd_wr && wr_valid) begin
            // full resolution held, used at once
            unique case (cmd_code)
                OTVO_CMD_WARN:  overtemp_warning_threshold_q  <= cmd_wdata;
                OTVO_CMD_OVP:   input_overvoltage_threshold_q <= cmd_wdata;
                OTVO_CMD_REACT: input_overvoltage_reaction_q  <= cmd_wdata[7:0];
                default: ;
            endcase
        end
    end

    // read back
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_rdata_q <= 16'h0000;
            cmd_ack_q   <= 1'b0;
        end else begin
            cmd_ack_q <= cmd_rd || cmd_wr;
            if (cmd_rd) begin
                unique case (cmd_code)
                    OTVO_CMD_WARN:  cmd_rdata_q <= overtemp_warning_threshold_q;
                    OTVO_CMD_OVP:   cmd_rdata_q <= input_overvoltage_threshold_q;
                    OTVO_CMD_REACT: cmd_rdata_q <= {8'h00, input_overvoltage_reaction_q};
                    default:        cmd_rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // comparators
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ot_warn_q    <= 1'b0;
            ov_now_q     <= 1'b0;
            ot_release_q <= 1'b0;
        end else if (!nvm_load_q) begin
            // thresholds still hold reset values while storage loads
            // disabled value never warns
            ot_warn_q <= warn_fix != OTVO_WARN_OFF_FIX &&
                otvo_fix_t'(temperature) >= warn_fix;
            ov_now_q <= otvo_fix_t'(power_input_voltage) >= ovp_fix;
            // release below warn limit or fault less hysteresis
            ot_release_q <= otvo_fix_t'(temperature) <
                ((warn_fix > fault_fix) ? fault_fix - OTVO_HYST_FIX : warn_fix);
        end
    end

    // status pulses for the status registers and host notification
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= '0;
        end else begin
            status_q <= '0;
            if (!nvm_load_q && !ot_warn_q && warn_fix != OTVO_WARN_OFF_FIX &&
                otvo_fix_t'(temperature) >= warn_fix) begin
                status_q.temp_bit          <= 1'b1;
                status_q.temp_warning_flag <= 1'b1;
                status_q.notify            <= 1'b1;
            end
            if (!nvm_load_q && !ov_now_q && otvo_fix_t'(power_input_voltage) >= ovp_fix) begin
                status_q.nota_bit               <= 1'b1;
                status_q.input_word_bit         <= 1'b1;
                status_q.input_overvoltage_flag <= 1'b1;
                status_q.notify                 <= 1'b1;
            end
            if (cmd_wr && !wr_valid && !nvm_load_q && !nvm_restore) begin
                status_q.cml_data <= 1'b1;
                status_q.notify   <= 1'b1;
            end
        end
    end

    otvo_sync u_pwm_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .din     (pwm_clk),
        .level_q (),
        .rise_q  (pwm_rise)
    );

    assign restart_wait_period_done =
        (rise_cnt_q + 20'h00001 >= soft_start_rise_time) &&
        (mult_cnt_q + 3'h1 >= otvo_wait_mult(ovp_delay_code));

    // overvoltage reaction sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= OTVO_ST_RUN;
            dly_cnt_q  <= 3'h0;
            rise_cnt_q <= 20'h00000;
            mult_cnt_q <= 3'h0;
            tries_q    <= 3'h0;
        end else begin
            unique case (state_q)
                OTVO_ST_RUN: begin
                    tries_q <= 3'h0;
                    if (converter_on && switching_q && ov_now_q) begin
                        if (ovp_reaction_code == OTVO_REACT_DELAYED) begin
                            state_q   <= OTVO_ST_DELAY;
                            dly_cnt_q <= otvo_delay_cycles(ovp_delay_code);
                        end else if (ovp_reaction_code == OTVO_REACT_IMMED) begin
                            state_q    <= (ovp_restart_count == OTVO_RETRY_NONE) ?
                                OTVO_ST_LATCH : OTVO_ST_WAIT;
                            rise_cnt_q <= 20'h00000;
                            mult_cnt_q <= 3'h0;
                        end
                    end
                end
                OTVO_ST_DELAY: begin
                    if (pwm_rise) begin
                        dly_cnt_q <= dly_cnt_q - 3'h1;
                        if (dly_cnt_q == 3'h1) begin
                            rise_cnt_q <= 20'h00000;
                            mult_cnt_q <= 3'h0;
                            if (!ov_now_q) begin
                                state_q <= OTVO_ST_RUN;
                            end else if (ovp_restart_count == OTVO_RETRY_NONE) begin
                                state_q <= OTVO_ST_LATCH;
                            end else begin
                                state_q <= OTVO_ST_WAIT;
                            end
                        end
                    end
                    if (!converter_on) begin
                        state_q <= OTVO_ST_RUN;
                    end
                end
                OTVO_ST_WAIT: begin
                    rise_cnt_q <= rise_cnt_q + 20'h00001;
                    if (rise_cnt_q + 20'h00001 >= soft_start_rise_time) begin
                        rise_cnt_q <= 20'h00000;
                        mult_cnt_q <= mult_cnt_q + 3'h1;
                    end
                    if (restart_wait_period_done) begin
                        mult_cnt_q <= 3'h0;
                        // attempt counted even if voltage stays high
                        if (!ov_now_q) begin
                            state_q <= OTVO_ST_RUN;
                        end else if (ovp_restart_count != OTVO_RETRY_FOREVER) begin
                            tries_q <= tries_q + 3'h1;
                            if (tries_q + 3'h1 >= ovp_restart_count) begin
                                state_q <= OTVO_ST_LATCH;
                            end
                        end
                    end
                    if (!converter_on) begin
                        state_q <= OTVO_ST_RUN;
                    end
                end
                OTVO_ST_LATCH: begin
                    // only a command off clears a latched shutdown
                    if (!converter_on) begin
                        state_q <= OTVO_ST_RUN;
                    end
                end
                default: state_q <= OTVO_ST_RUN;
            endcase
        end
    end

    // no start while an overvoltage is present, even when ignoring it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            switching_q <= 1'b0;
        end else begin
            // switching continues while the delay counts
            switching_q <= (state_q == OTVO_ST_RUN || state_q == OTVO_ST_DELAY) &&
                converter_on &&
                (switching_q || !ov_now_q) &&
                !(ov_now_q && ovp_reaction_code == OTVO_REACT_IMMED);
        end
    end

    invalid_react_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cmd_wr && cmd_code == OTVO_CMD_REACT && cmd_wdata[7:6] == OTVO_REACT_BAD &&
        !nvm_load_q && !nvm_restore |=> status_q.cml_data &&
        input_overvoltage_reaction_q == $past(input_overvoltage_reaction_q))
        else $error("bad reaction code accepted");
    react_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cmd_wr && cmd_code == OTVO_CMD_REACT && wr_valid && !nvm_load_q && !nvm_restore
        |=> input_overvoltage_reaction_q == $past(cmd_wdata[7:0]))
        else $error("reaction byte not stored");
    ignore_keeps_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == OTVO_ST_RUN && switching_q && converter_on && ov_now_q &&
        ovp_reaction_code == OTVO_REACT_IGNORE ##1 converter_on |-> switching_q)
        else $error("switching stopped while ignoring");
    immed_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == OTVO_ST_RUN && switching_q && converter_on && ov_now_q &&
        ovp_reaction_code == OTVO_REACT_IMMED |=> !switching_q ##1 !switching_q)
        else $error("immediate shutdown missed");
    delay_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(state_q == OTVO_ST_DELAY) |->
        dly_cnt_q == otvo_delay_cycles($past(ovp_delay_code)))
        else $error("wrong shutdown delay");
    ov_status_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(ov_now_q) |-> status_q.input_overvoltage_flag &&
        status_q.nota_bit && status_q.input_word_bit && status_q.notify)
        else $error("overvoltage status missing");
    warn_status_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(ot_warn_q) |-> status_q.temp_warning_flag && status_q.temp_bit)
        else $error("warning status missing");
    warn_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        warn_fix == OTVO_WARN_OFF_FIX |=> !ot_warn_q)
        else $error("disabled warning fired");
    retry_forever_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == OTVO_ST_WAIT && ovp_restart_count == OTVO_RETRY_FOREVER
        |=> state_q != OTVO_ST_LATCH)
        else $error("infinite retry latched off");

    delayed_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == OTVO_ST_DELAY ##[1:200] state_q == OTVO_ST_WAIT);
    latch_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == OTVO_ST_WAIT ##1 state_q == OTVO_ST_LATCH);
    restart_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == OTVO_ST_WAIT ##1 state_q == OTVO_ST_RUN && converter_on);
    invalid_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        status_q.cml_data);
endmodule : otvo_limits

// ### design/otvo_pkg.sv
// otvo_pkg: command codes, field layout, limits and decodes for the
// overtemperature warning / input overvoltage command block.
// assumes telemetry arrives as signed fixed point with OTVO_FRAC fraction bits.
package otvo_pkg;

    // command codes
    localparam logic [7:0] OTVO_CMD_WARN  = 8'h51;
    localparam logic [7:0] OTVO_CMD_OVP   = 8'h55;
    localparam logic [7:0] OTVO_CMD_REACT = 8'h56;

    // linear word layout
    localparam int OTVO_EXP_MSB = 15;
    localparam int OTVO_EXP_LSB = 11;
    localparam int OTVO_MAN_MSB = 10;
    localparam logic [4:0] OTVO_WARN_EXP_RST = 5'h00;
    localparam logic [4:0] OTVO_OVP_EXP_RST  = 5'h1E;

    // reaction byte layout
    localparam int OTVO_CODE_LSB  = 6;
    localparam int OTVO_COUNT_LSB = 3;
    localparam int OTVO_DELAY_LSB = 0;
    localparam logic [1:0] OTVO_REACT_IGNORE  = 2'h0;
    localparam logic [1:0] OTVO_REACT_DELAYED = 2'h1;
    localparam logic [1:0] OTVO_REACT_IMMED   = 2'h2;
    localparam logic [1:0] OTVO_REACT_BAD     = 2'h3;
    localparam logic [2:0] OTVO_RETRY_NONE    = 3'h0;
    localparam logic [2:0] OTVO_RETRY_FOREVER = 3'h7;

    // fixed point used for every comparison
    localparam int OTVO_FRAC  = 8;
    localparam int OTVO_FIX_W = 40;
    localparam int OTVO_TEL_W = 24;
    typedef logic signed [OTVO_FIX_W-1:0] otvo_fix_t;

    // limits in their own units
    localparam int OTVO_WARN_MIN_C  = 0;
    localparam int OTVO_WARN_MAX_C  = 160;
    localparam int OTVO_WARN_OFF_C  = 255;
    localparam int OTVO_OT_HYST_C   = 20;
    localparam int OTVO_OVP_MIN_V   = 4;
    localparam int OTVO_OVP_MAX_V   = 20;
    localparam int OTVO_OVP_STEP_SH = 2;    // 0.25 V steps
    localparam otvo_fix_t OTVO_WARN_OFF_FIX = otvo_fix_t'(OTVO_WARN_OFF_C * (1 << OTVO_FRAC));
    localparam otvo_fix_t OTVO_HYST_FIX     = otvo_fix_t'(OTVO_OT_HYST_C * (1 << OTVO_FRAC));

    typedef struct packed {
        logic notify;
        logic cml_data;
        logic temp_bit;
        logic temp_warning_flag;
        logic nota_bit;
        logic input_word_bit;
        logic input_overvoltage_flag;
    } otvo_status_t;

    typedef enum logic [3:0] {
        OTVO_ST_RUN   = 4'h1,
        OTVO_ST_DELAY = 4'h2,
        OTVO_ST_WAIT  = 4'h4,
        OTVO_ST_LATCH = 4'h8
    } otvo_state_t;

    // value = signed mantissa * 2^signed exponent, in fixed point
    function automatic otvo_fix_t otvo_lin_to_fix(input logic [15:0] w);
        int        sh;
        otvo_fix_t m;
        m  = otvo_fix_t'($signed(w[OTVO_MAN_MSB:0]));
        sh = int'($signed(w[OTVO_EXP_MSB:OTVO_EXP_LSB])) + OTVO_FRAC;
        if (sh >= 0) begin
            return m <<< sh;
        end
        return m >>> (-sh);
    endfunction : otvo_lin_to_fix

    // switching cycles before a delayed shutdown
    function automatic logic [2:0] otvo_delay_cycles(input logic [2:0] c);
        if (c <= 3'h1) begin
            return 3'h1;
        end
        if (c <= 3'h4) begin
            return 3'h3;
        end
        return 3'h7;
    endfunction : otvo_delay_cycles

    // restart wait period in multiples of the rise time
    function automatic logic [2:0] otvo_wait_mult(input logic [2:0] c);
        return (c <= 3'h1) ? 3'h1 : c;
    endfunction : otvo_wait_mult

endpackage : otvo_pkg

// ### design/otvo_sync.sv
// otvo_sync: three-stage synchroniser with agreement filter and rise pulse.
// assumes the input is asynchronous to ref_clk and slower than two periods.
`timescale 1ns/1ps
module otvo_sync (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      level_q,
    output logic      rise_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
                rise_q  <= s3_q & ~level_q;
            end
        end
    end
endmodule : otvo_sync

// ### tb/otvo_host.sv
// otvo_host: host model for the command port, one transfer at a time.
// assumes ref_clk from the bench; strobes move 2 ns after an edge.
`timescale 1ns/1ps
module otvo_host (
    input  wire logic        ref_clk,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata_q,
    input  wire logic        cmd_ack_q
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // spare cycle after each transfer: a strobe never moves twice at one edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic a);
        cmd_wr = w;
        cmd_rd = ~w;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge ref_clk);
        #2;
        q = cmd_rdata_q;
        a = cmd_ack_q;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = ~d;
        @(posedge ref_clk);
        #2;
    endtask : xfer
endmodule : otvo_host

// ### tb/test_otvo_limits.sv
// test_otvo_limits: command, telemetry and shutdown scenarios.
// assumes otvo_host on the command port and a free pwm_clk at 400 ns.
`timescale 1ns/1ps
module test_otvo_limits import otvo_pkg::*;;
    logic                  ref_clk = 1'b0;
    logic                  pwm_clk = 1'b0;
    logic                  reset_n, converter_on, cmd_wr, cmd_rd, cmd_ack_q, sw, rel, a;
    logic [7:0]            cmd_code;
    logic [15:0]           cmd_wdata, cmd_rdata_q, q;
    logic signed [23:0]    temp, vin;
    otvo_status_t          status_q, seen;
    logic                  nvm_restore = 1'b0;
    int                    failures = 0;
    int                    compares = 0;
    always #25 ref_clk = ~ref_clk;
    always #200 pwm_clk = ~pwm_clk;
    always @(posedge ref_clk) seen <= seen | status_q;
    otvo_host host_u (.ref_clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata_q,
        .cmd_ack_q);
    otvo_limits dut_u (.ref_clk, .reset_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
        .nvm_restore, .nvm_warn_mantissa(11'h064), .nvm_ovp_mantissa(11'h030),
        .nvm_reaction(8'h80), .temperature(temp), .power_input_voltage(vin),
        .overtemp_fault_threshold(16'h0096), .soft_start_rise_time(20'h0000A),
        .converter_on, .pwm_clk, .cmd_rdata_q, .cmd_ack_q, .status_q,
        .ot_release_q(rel), .switching_q(sw));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : cyc
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        seen = '0;
        host_u.xfer(1'b1, c, d, q, a);
    endtask : wr
    task automatic rd(input logic [7:0] c);
        host_u.xfer(1'b0, c, 16'h0000, q, a);
    endtask : rd
    // restart below threshold, set the reaction, then push input to 10 V
    task automatic ov_run(input logic [7:0] r);
        vin = 24'h000800;
        converter_on = 1'b0;
        cyc(2);
        converter_on = 1'b1;
        wr(OTVO_CMD_REACT, {8'h00, r});
        vin = 24'h000A00;
    endtask : ov_run
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {reset_n, converter_on, seen, temp, vin} = {2'b01, 7'h00, 24'h001900, 24'h000800};
        cyc(16);
        reset_n = 1'b1;
        cyc(3);
        rd(OTVO_CMD_WARN);
        chk(q, 16'h0064);
        chk({15'h0, a}, 16'h0001);
        rd(OTVO_CMD_OVP);
        chk(q, 16'hF030);
        rd(OTVO_CMD_REACT);
        chk(q, 16'h0080);
        wr(OTVO_CMD_WARN, 16'h00C8);
        chk(16'(seen), 16'h0060);
        wr(OTVO_CMD_REACT, 16'h00C0);
        chk(16'(seen), 16'h0060);
        wr(OTVO_CMD_OVP, 16'hF051);
        chk(16'(seen), 16'h0060);
        wr(OTVO_CMD_OVP, 16'hF028);
        rd(OTVO_CMD_OVP);
        chk(q, 16'hF028);
        seen = '0;
        temp = 24'h006400;
        cyc(4);
        chk(16'(seen), 16'h0058);
        chk({15'h0, rel}, 16'h0000);
        temp = 24'h001900;
        wr(OTVO_CMD_WARN, 16'h00FF);
        temp = 24'h006400;
        cyc(4);
        chk(16'(seen), 16'h0000);
        chk({15'h0, rel}, 16'h0001);
        ov_run(8'h80);
        cyc(6);
        chk(16'(seen), 16'h0047);
        chk({15'h0, sw}, 16'h0000);
        vin = 24'h000800;
        cyc(40);
        chk({15'h0, sw}, 16'h0000);
        ov_run(8'h4D);
        cyc(20);
        chk({15'h0, sw}, 16'h0001);
        cyc(60);
        chk({15'h0, sw}, 16'h0000);
        ov_run(8'h88);
        cyc(4);
        chk({15'h0, sw}, 16'h0000);
        vin = 24'h000800;
        cyc(30);
        chk({15'h0, sw}, 16'h0001);
        ov_run(8'h90);
        cyc(30);
        vin = 24'h000800;
        cyc(30);
        chk({15'h0, sw}, 16'h0000);
        ov_run(8'hB8);
        cyc(40);
        vin = 24'h000800;
        cyc(30);
        chk({15'h0, sw}, 16'h0001);
        ov_run(8'h00);
        cyc(80);
        chk({15'h0, sw}, 16'h0001);
        wr(OTVO_CMD_WARN, 16'hF193);
        rd(OTVO_CMD_WARN);
        chk(q, 16'hF193);
        wr(OTVO_CMD_OVP, 16'hF814);
        nvm_restore = 1'b1;
        cyc(1);
        nvm_restore = 1'b0;
        rd(OTVO_CMD_WARN);
        chk(q, 16'h0065);
        rd(OTVO_CMD_OVP);
        chk(q, 16'hF028);
        tally_and_finish();
    end
endmodule : test_otvo_limits
